// [hw/core_timing_params.svh]
`ifndef CORE_TIMING_PARAMS_SVH
`define CORE_TIMING_PARAMS_SVH

// clock cycles per state
`define CLK_PER_STATE 2
// extra states for add, subtract and compare
`define ALU_PORT_EXTRA 4'h1
`define ALU_SFR_EXTRA 4'h2
// extra states for increment and decrement
`define INC_PORT_EXTRA 4'h2
`define INC_SFR_EXTRA 4'h3
// external operand base penalty, added to the wait count
`define EXT_BASE_EXTRA 6'h02
// code fetch figures
`define ONCHIP_BYTES_PER_STATE 5'h02
`define PAGE_STATES_PER_BYTE 5'h01
`define NONPAGE_STATES_PER_BYTE 5'h02
`define QUEUE_DEPTH 5'h08
// step field codes
`define STEP_ONE 2'h0
`define STEP_TWO 2'h1
`define STEP_FOUR 2'h2
`define STEP_RSVD 2'h3

`endif

// [hw/core_timing_pkg.sv]
package core_timing_pkg;

    typedef enum logic [2:0] {op_add, op_add_with_carry_op, op_sub, op_subtract_with_borrow_op, op_cmp, op_inc, op_dec} op_t;
    typedef enum logic [1:0] {loc_onchip, loc_port, loc_sfr, loc_ext} loc_t;
    typedef enum logic [1:0] {w_byte, w_word, w_dword} width_t;
    typedef enum logic [1:0] {ext_none, ext_zero, ext_one} imm_ext_t;

endpackage : core_timing_pkg

// [hw/fetch_link_if.sv]
`timescale 1ns/100ps
interface fetch_link_if;
    logic state_tick;
    logic code_external;
    logic page_mode;
    logic [3:0] wait_states;
    logic consume;
    logic [2:0] consume_len;
    logic [4:0] bytes_avail;

    modport core (output state_tick, output code_external, output page_mode,
        output wait_states, output consume, output consume_len, input bytes_avail);
    modport fetch (input state_tick, input code_external, input page_mode,
        input wait_states, input consume, input consume_len, output bytes_avail);
endinterface : fetch_link_if

// [hw/fetch_queue.sv]
`timescale 1ns/100ps
`include "core_timing_params.svh"
module fetch_queue (
    input wire logic clk,
    input wire logic rstn,
    fetch_link_if.fetch link
);

    logic [4:0] count_reg;
    logic [4:0] count_next;
    logic [4:0] timer_reg;
    logic [4:0] cost;
    logic [4:0] add;
    logic [5:0] sum;

    ////////////////////////////////////////////////////////////////////////
    // byte cost of one external fetch in states
    always_comb
    begin
        if (link.page_mode)
            cost = 5'(`PAGE_STATES_PER_BYTE * ({1'b0, link.wait_states} + 5'h01));
        else
            cost = 5'(`NONPAGE_STATES_PER_BYTE * ({1'b0, link.wait_states} + 5'h01));
    end

    always_comb
    begin
        add = 5'h00;
        if (link.state_tick)
        begin
            if (!link.code_external)
                add = `ONCHIP_BYTES_PER_STATE;
            else if (timer_reg + 5'h01 >= cost)
                add = 5'h01;
        end
        sum = {1'b0, count_reg} + {1'b0, add};
        if (link.consume)
            sum = sum - {3'h0, link.consume_len};
        if (sum > {1'b0, `QUEUE_DEPTH})
            count_next = `QUEUE_DEPTH;
        else
            count_next = sum[4:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // prefetch runs alongside execution
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            count_reg <= 5'h00;
        else
            count_reg <= count_next;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            timer_reg <= 5'h00;
        else if (!link.code_external || count_reg >= `QUEUE_DEPTH)
            timer_reg <= 5'h00;
        else if (link.state_tick)
            timer_reg <= (timer_reg + 5'h01 >= cost) ? 5'h00 : timer_reg + 5'h01;
    end

    assign link.bytes_avail = count_reg;

endmodule : fetch_queue

// [hw/cpu_fetch_execute_timing.sv]
// Summary of operation
// - a state lasts exactly two clock cycles
// - fetch and execute run concurrently; either can limit throughput
// - on-chip code fetch delivers 16 bits per state, never limiting instructions of up to two bytes
// - external code is buffered ahead in a prefetch queue
// - page mode fetch costs one state per byte
// - non-page mode fetch costs two states per byte
// - instruction time is the larger of execution and fetch limit
// - add, subtract, compare: port plus 1, peripheral register plus 2
// - increment, decrement direct: port plus 2, peripheral plus 3
// - external operand adds N+2 states
// - doubled external variants add 2(N+2) states
// - three-byte increment and decrement step by 1, 2 or 4
// - accumulator increment adds one in one state
// - compare computes destination minus source
// - dword compare with zero- or one-extended 16-bit immediate
// - accumulator add takes register, direct, indirect or immediate source
// - add with carry and subtract with borrow include the carry flag
// - step code 00 one, 01 two, 10 four, 11 reserved
`timescale 1ns/100ps
`include "core_timing_params.svh"
module cpu_fetch_execute_timing
    import core_timing_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic code_external,
    input wire logic page_mode,
    input wire logic [3:0] wait_states,
    input wire logic instr_valid,
    input wire op_t instr_op,
    input wire width_t instr_width,
    input wire loc_t instr_loc,
    input wire logic instr_double_ext,
    input wire logic [2:0] instr_len,
    input wire logic [3:0] instr_base_states,
    input wire logic [1:0] instr_step,
    input wire imm_ext_t instr_imm_ext,
    input wire logic [31:0] dest_data,
    input wire logic [31:0] src_data,
    input wire logic carry_in,
    output logic instr_ready,
    output logic done,
    output logic result_write,
    output logic [31:0] result,
    output logic carry_out,
    output logic zero_out,
    output logic neg_out,
    output logic step_err,
    output logic [5:0] states_used
);

    typedef enum logic [1:0] {st_idle, st_wait_fetch, st_exec} exec_state_t;

    fetch_link_if link();

    exec_state_t st_reg;
    logic phase_reg;
    logic tick;
    op_t op_reg;
    width_t width_reg;
    logic [2:0] len_reg;
    logic [1:0] step_reg;
    logic [31:0] dst_reg;
    logic [31:0] src_reg;
    logic carry_reg;
    logic [5:0] total_reg;
    logic [5:0] total_next;
    logic [5:0] cnt_reg;
    logic [5:0] used_reg;
    logic [3:0] extra;
    logic [5:0] ext_extra;
    logic [31:0] src_eff;
    logic [31:0] step_val;
    logic [32:0] raw;
    logic [31:0] mask;
    logic [31:0] res_next;
    logic cy_next;
    logic neg_next;
    logic accept;
    logic start;
    logic finish;

    logic instr_ready_reg;
    logic done_reg;
    logic result_write_reg;
    logic [31:0] result_reg;
    logic carry_reg_out;
    logic zero_reg;
    logic neg_reg;
    logic step_err_reg;

    fetch_queue u_fetch (
        .clk(clk),
        .rstn(rstn),
        .link(link)
    );

    ////////////////////////////////////////////////////////////////////////
    // state timing: one tick every two clocks
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            phase_reg <= 1'b0;
        else
            phase_reg <= ~phase_reg;
    end

    assign tick = phase_reg;
    assign link.state_tick = tick;
    assign link.code_external = code_external;
    assign link.page_mode = page_mode;
    assign link.wait_states = wait_states;
    assign link.consume = start;
    assign link.consume_len = len_reg;

    ////////////////////////////////////////////////////////////////////////
    // extra states for operand location
    always_comb
    begin
        extra = 4'h0;
        if (instr_op == op_inc || instr_op == op_dec)
        begin
            if (instr_loc == loc_port)
                extra = `INC_PORT_EXTRA;
            else if (instr_loc == loc_sfr)
                extra = `INC_SFR_EXTRA;
        end
        else
        begin
            if (instr_loc == loc_port)
                extra = `ALU_PORT_EXTRA;
            else if (instr_loc == loc_sfr)
                extra = `ALU_SFR_EXTRA;
        end
        ext_extra = 6'h00;
        if (instr_loc == loc_ext)
        begin
            ext_extra = {2'h0, wait_states} + `EXT_BASE_EXTRA;
            if (instr_double_ext)
                ext_extra = 6'(ext_extra << 1);
        end
        total_next = {2'h0, instr_base_states} + {2'h0, extra} + ext_extra;
        if (total_next == 6'h00)
            total_next = 6'h01;
    end

    assign accept = instr_valid && instr_ready_reg;
    assign start = (st_reg == st_wait_fetch) && tick
        && (link.bytes_avail >= {2'h0, len_reg});
    assign finish = (start && total_reg == 6'h01)
        || ((st_reg == st_exec) && tick && (cnt_reg == 6'h02));

    ////////////////////////////////////////////////////////////////////////
    // execution sequencer
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            st_reg <= st_idle;
        else
        begin
            case (st_reg)
                st_idle:
                    if (accept)
                        st_reg <= st_wait_fetch;
                st_wait_fetch:
                    if (finish)
                        st_reg <= st_idle;
                    else if (start)
                        st_reg <= st_exec;
                st_exec:
                    if (finish)
                        st_reg <= st_idle;
                default:
                    st_reg <= st_idle;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            op_reg <= op_add;
            width_reg <= w_byte;
            len_reg <= 3'h0;
            step_reg <= 2'h0;
            dst_reg <= 32'h0000_0000;
            src_reg <= 32'h0000_0000;
            carry_reg <= 1'b0;
            total_reg <= 6'h00;
        end
        else if (accept)
        begin
            op_reg <= instr_op;
            width_reg <= instr_width;
            len_reg <= instr_len;
            step_reg <= instr_step;
            dst_reg <= dest_data;
            carry_reg <= carry_in;
            total_reg <= total_next;
            case (instr_imm_ext)
                ext_zero: src_reg <= {16'h0000, src_data[15:0]};
                ext_one: src_reg <= {16'hffff, src_data[15:0]};
                default: src_reg <= src_data;
            endcase
        end
    end

    // execution counts states from start; time spent waiting on fetch is not included
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            cnt_reg <= 6'h00;
        else if (start)
            cnt_reg <= total_reg;
        else if (st_reg == st_exec && tick)
            cnt_reg <= cnt_reg - 6'h01;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            used_reg <= 6'h00;
        else if (accept)
            used_reg <= 6'h00;
        else if (st_reg != st_idle && tick && used_reg != 6'h3f)
            used_reg <= used_reg + 6'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    // arithmetic
    always_comb
    begin
        case (step_reg)
            `STEP_TWO: step_val = 32'h0000_0002;
            `STEP_FOUR: step_val = 32'h0000_0004;
            default: step_val = 32'h0000_0001;
        endcase
        case (width_reg)
            w_word: mask = 32'h0000_ffff;
            w_dword: mask = 32'hffff_ffff;
            default: mask = 32'h0000_00ff;
        endcase
        src_eff = src_reg & mask;
        case (op_reg)
            op_add: raw = {1'b0, dst_reg & mask} + {1'b0, src_eff};
            op_add_with_carry_op: raw = {1'b0, dst_reg & mask} + {1'b0, src_eff} + {32'h0, carry_reg};
            op_subtract_with_borrow_op: raw = {1'b0, dst_reg & mask} - {1'b0, src_eff} - {32'h0, carry_reg};
            op_inc: raw = {1'b0, dst_reg & mask} + {1'b0, step_val};
            op_dec: raw = {1'b0, dst_reg & mask} - {1'b0, step_val};
            default: raw = {1'b0, dst_reg & mask} - {1'b0, src_eff};
        endcase
        res_next = raw[31:0] & mask;
        case (width_reg)
            w_word:
            begin
                cy_next = raw[16];
                neg_next = raw[15];
            end
            w_dword:
            begin
                cy_next = raw[32];
                neg_next = raw[31];
            end
            default:
            begin
                cy_next = raw[8];
                neg_next = raw[7];
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // output registers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            instr_ready_reg <= 1'b1;
        else if (accept)
            instr_ready_reg <= 1'b0;
        else if (finish)
            instr_ready_reg <= 1'b1;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            done_reg <= 1'b0;
            result_write_reg <= 1'b0;
        end
        else
        begin
            done_reg <= finish;
            result_write_reg <= finish && (op_reg != op_cmp);
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            result_reg <= 32'h0000_0000;
            carry_reg_out <= 1'b0;
            zero_reg <= 1'b0;
            neg_reg <= 1'b0;
            step_err_reg <= 1'b0;
        end
        else if (finish)
        begin
            result_reg <= (op_reg == op_cmp) ? dst_reg : res_next;
            carry_reg_out <= cy_next;
            zero_reg <= (res_next == 32'h0000_0000);
            neg_reg <= neg_next;
            step_err_reg <= (op_reg == op_inc || op_reg == op_dec)
                && (step_reg == `STEP_RSVD);
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            states_used <= 6'h00;
        else if (finish)
            states_used <= used_reg + 6'h01;
    end

    assign instr_ready = instr_ready_reg;
    assign done = done_reg;
    assign result_write = result_write_reg;
    assign result = result_reg;
    assign carry_out = carry_reg_out;
    assign zero_out = zero_reg;
    assign neg_out = neg_reg;
    assign step_err = step_err_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    chk_state_two_clk: assert property (tick |=> !tick ##1 tick)
        else $error("state tick not every two clocks");
    chk_alu_port_extra: assert property (accept && instr_op == op_add && instr_loc == loc_port
        |=> total_reg == 6'($past(instr_base_states)) + 6'h01)
        else $error("port extra for add wrong");
    chk_inc_sfr_extra: assert property (accept && instr_op == op_inc && instr_loc == loc_sfr
        |=> total_reg == 6'($past(instr_base_states)) + 6'h03)
        else $error("peripheral extra for increment wrong");
    chk_ext_single: assert property (accept && instr_loc == loc_ext && !instr_double_ext
        |=> total_reg == 6'($past(instr_base_states)) + 6'($past(wait_states)) + 6'h02)
        else $error("external penalty wrong");
    chk_ext_double: assert property (accept && instr_loc == loc_ext && instr_double_ext
        |=> total_reg == 6'($past(instr_base_states)) + 6'h2 * (6'($past(wait_states)) + 6'h02))
        else $error("doubled external penalty wrong");
    chk_fetch_gate: assert property (st_reg == st_wait_fetch && tick
        && link.bytes_avail < {2'h0, len_reg} |=> st_reg == st_wait_fetch)
        else $error("execution started without fetched bytes");
    chk_onchip_fetch: assert property (st_reg == st_wait_fetch && !code_external
        && len_reg <= 3'h2 && link.bytes_avail >= 5'h02 |-> ##[0:1] start)
        else $error("on-chip fetch throttled execution");
    chk_cmp_no_write: assert property (finish && op_reg == op_cmp
        |=> done && !result_write && result == $past(dst_reg))
        else $error("compare altered destination");
    chk_step_reserved: assert property (finish && op_reg == op_inc && step_reg == 2'h3
        |=> step_err)
        else $error("reserved step not flagged");
    chk_done_pulse: assert property (done |-> instr_ready ##1 !done)
        else $error("done not a single pulse");

    cov_ext_fetch: cover property (accept && instr_loc == loc_ext ##[1:200] done);
    cov_fetch_stall: cover property (st_reg == st_wait_fetch && tick && !start);
    cov_cmp_done: cover property (finish && op_reg == op_cmp);
    cov_step_four: cover property (finish && op_reg == op_dec && step_reg == 2'h2);

endmodule : cpu_fetch_execute_timing

// [test/ext_code_mem_model.sv]
`timescale 1ns/100ps
module ext_code_mem_model (
    input wire logic clk,
    input wire logic want_external,
    input wire logic want_page,
    input wire logic [3:0] want_wait,
    output logic code_external,
    output logic page_mode,
    output logic [3:0] wait_states
);
    ////////////////////////////////////////////////////////////////////////////////
    // external memory set-up seen by the core, taken on the rising edge
    initial
    begin
        code_external = 1'b0;
        page_mode = 1'b0;
        wait_states = 4'h0;
    end

    always @(posedge clk)
    begin
        code_external <= want_external;
        page_mode <= want_page;
        wait_states <= want_wait;
    end
endmodule : ext_code_mem_model

// [test/tb_cpu_fetch_execute_timing.sv]
`timescale 1ns/100ps
module tb_cpu_fetch_execute_timing
    import core_timing_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic want_external = 1'b0;
    logic want_page = 1'b0;
    logic [3:0] want_wait = 4'h0;
    logic code_external;
    logic page_mode;
    logic [3:0] wait_states;
    logic instr_valid = 1'b0;
    op_t instr_op = op_add;
    width_t instr_width = w_byte;
    loc_t instr_loc = loc_onchip;
    logic instr_double_ext = 1'b0;
    logic [2:0] instr_len = 3'h1;
    logic [3:0] instr_base_states = 4'h1;
    logic [1:0] instr_step = 2'h0;
    imm_ext_t instr_imm_ext = ext_none;
    logic [31:0] dest_data = 32'h0;
    logic [31:0] src_data = 32'h0;
    logic carry_in = 1'b0;
    logic instr_ready;
    logic done;
    logic result_write;
    logic [31:0] result;
    logic carry_out;
    logic zero_out;
    logic neg_out;
    logic step_err;
    logic [5:0] states_used;
    int fails = 0;
    int check_count = 0;
    int cycles = 0;
    logic warm = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // clock, far side and core
    always #50 clk = ~clk;

    ext_code_mem_model mem_model (.clk, .want_external, .want_page, .want_wait,
        .code_external, .page_mode, .wait_states);

    cpu_fetch_execute_timing dut (.clk, .rstn, .code_external, .page_mode, .wait_states,
        .instr_valid, .instr_op, .instr_width, .instr_loc, .instr_double_ext, .instr_len,
        .instr_base_states, .instr_step, .instr_imm_ext, .dest_data, .src_data, .carry_in,
        .instr_ready, .done, .result_write, .result, .carry_out, .zero_out, .neg_out,
        .step_err, .states_used);

    ////////////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic report_and_stop();
        if (fails == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want)
        begin
            fails++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask : check

    task automatic set_op(input op_t op, input width_t w, input loc_t loc,
        input logic [2:0] len, input logic [3:0] base);
        instr_op = op;
        instr_width = w;
        instr_loc = loc;
        instr_len = len;
        instr_base_states = base;
    endtask : set_op

    // issues one instruction and judges the answer; bump keeps a request up while busy
    task automatic run(input logic bump);
        logic [32:0] full;
        logic [31:0] m;
        logic [31:0] d;
        logic [31:0] s;
        logic [31:0] r;
        logic cy;
        logic alu;
        op_t op;
        int ex;
        int fl;
        int n;
        op = instr_op;
        m = (instr_width == w_byte) ? 32'h000000ff :
            (instr_width == w_word) ? 32'h0000ffff : 32'hffffffff;
        s = (instr_imm_ext == ext_zero) ? {16'h0000, src_data[15:0]} :
            (instr_imm_ext == ext_one) ? {16'hffff, src_data[15:0]} : src_data;
        alu = !(op == op_inc || op == op_dec);
        if (!alu)
            s = (instr_step == 2'h1) ? 32'h2 : (instr_step == 2'h2) ? 32'h4 : 32'h1;
        d = dest_data & m;
        s = s & m;
        case (op)
            op_add, op_inc: full = d + s;
            op_add_with_carry_op: full = d + s + carry_in;
            op_subtract_with_borrow_op: full = d - s - carry_in;
            default: full = d - s;
        endcase
        r = full[31:0] & m;
        cy = (instr_width == w_byte) ? full[8] : (instr_width == w_word) ? full[16] : full[32];
        ex = (instr_base_states == 4'h0) ? 1 : int'(instr_base_states);
        if (instr_loc == loc_port) ex += alu ? 1 : 2;
        if (instr_loc == loc_sfr) ex += alu ? 2 : 3;
        if (instr_loc == loc_ext) ex += (instr_double_ext ? 2 : 1) * (int'(want_wait) + 2);
        fl = !want_external ? 0 : (want_page ? 1 : 2) * int'(instr_len) * (int'(want_wait) + 1);
        if (fl > ex) ex = fl;
        n = 0;
        while (instr_ready !== 1'b1 && n < 400)
        begin
            @(negedge clk);
            n++;
        end
        instr_valid = 1'b1;
        @(negedge clk);
        if (bump)
        begin
            check(instr_ready, 1'b0);
            instr_op = op_sub;
            @(negedge clk);
            @(negedge clk);
        end
        instr_valid = 1'b0;
        n = bump ? 3 : 1;
        while (done !== 1'b1 && n < 400)
        begin
            @(negedge clk);
            n++;
        end
        check(done, 1'b1);
        check(instr_ready, 1'b1);
        // timing is judged once the queue has settled
        if (!warm)
        begin
            check(states_used, ex[5:0]);
            check(n >= 2 * ex, 1'b1);
        end
        check(result_write, op != op_cmp);
        check(result, (op == op_cmp) ? dest_data : r);
        check(zero_out, r == 32'h0);
        check(neg_out, (r & ~(m >> 1)) != 32'h0);
        if (alu)
            check(carry_out, cy);
        check(step_err, !alu && instr_step == 2'h3);
    endtask : run

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic s_add_family();
        op_t ops[4] = '{op_add, op_add_with_carry_op, op_sub, op_subtract_with_borrow_op};
        carry_in = 1'b1;
        for (int k = 0; k < 8; k++)
        begin
            dest_data = k[2] ? 32'hffffffff : 32'h000000f0;
            src_data = k[2] ? 32'h00000001 : 32'h00000023;
            set_op(ops[k % 4], k[2] ? w_dword : w_byte, loc_onchip, k[0] ? 3'h2 : 3'h1, 4'h1);
            run(1'b0);
        end
    endtask : s_add_family

    task automatic s_acc_step();
        dest_data = 32'h000000ff;
        set_op(op_inc, w_byte, loc_onchip, 3'h1, 4'h1);
        run(1'b0);
        for (int k = 0; k < 8; k++)
        begin
            dest_data = 32'h00010000;
            instr_step = k[2:1];
            set_op(k[0] ? op_dec : op_inc, width_t'(2'(k % 3)), loc_onchip, 3'h3, 4'h4);
            run(1'b0);
        end
        instr_step = 2'h0;
    endtask : s_acc_step

    task automatic s_locations();
        want_wait = 4'h3;
        dest_data = 32'h00001000;
        src_data = 32'h00000001;
        for (int k = 0; k < 10; k++)
        begin
            set_op(k[0] ? op_inc : op_add, w_word, (k < 8) ? loc_t'(k[2:1]) : loc_ext, 3'h2, 4'h2);
            instr_double_ext = (k >= 8);
            run(1'b0);
        end
        instr_double_ext = 1'b0;
        want_wait = 4'h0;
    endtask : s_locations

    task automatic s_compare();
        dest_data = 32'h00001234;
        src_data = 32'h00001234;
        set_op(op_cmp, w_word, loc_onchip, 3'h3, 4'h3);
        run(1'b0);
        src_data = 32'hdead8001;
        for (int k = 0; k < 2; k++)
        begin
            dest_data = k[0] ? 32'hffff8000 : 32'h00008001;
            instr_imm_ext = k[0] ? ext_one : ext_zero;
            set_op(op_cmp, w_dword, loc_onchip, 3'h5, 4'h6);
            run(1'b0);
        end
        instr_imm_ext = ext_none;
    endtask : s_compare

    task automatic s_fetch_limit();
        want_external = 1'b1;
        dest_data = 32'h00000011;
        src_data = 32'h00000022;
        for (int k = 0; k < 12; k++)
        begin
            want_page = (k < 5) || (k >= 10);
            want_wait = (k == 10) ? 4'h1 : 4'h0;
            set_op(op_add, w_byte, loc_onchip, 3'((k % 5) + 1), (k == 11) ? 4'hc : 4'h1);
            warm = 1'b1;
            repeat (10) run(1'b0);
            warm = 1'b0;
            run(1'b0);
        end
        want_external = 1'b0;
        want_wait = 4'h0;
    endtask : s_fetch_limit

    task automatic s_refused();
        set_op(op_add, w_byte, loc_onchip, 3'h1, 4'h3);
        run(1'b1);
    endtask : s_refused

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence and hang guard
    initial
    begin
        repeat (12) @(negedge clk);
        check(instr_ready, 1'b1);
        check(done, 1'b0);
        check(states_used, 6'h00);
        rstn = 1'b1;
        // let the on-chip queue fill before the first instruction
        repeat (4) @(negedge clk);
        s_add_family();
        s_acc_step();
        s_locations();
        s_compare();
        s_fetch_limit();
        s_refused();
        report_and_stop();
    end

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fails++;
            report_and_stop();
        end
    end
endmodule : tb_cpu_fetch_execute_timing
